/* hdl/ssp_pkg.sv */
package ssp_pkg;

	// device register offsets on the device's own register port
	localparam logic [2:0] BUF_OFS  = 3'h0;
	localparam logic [2:0] ADDR_OFS = 3'h1;
	localparam logic [2:0] STAT_OFS = 3'h2;
	localparam logic [2:0] CTL1_OFS = 3'h3;
	localparam logic [2:0] CTL2_OFS = 3'h4;
	localparam logic [2:0] FLAG_OFS = 3'h5;

	// field positions
	localparam int ST_BF   = 0;
	localparam int ST_UA   = 1;
	localparam int ST_RW   = 2;
	localparam int ST_S    = 3;
	localparam int C1_TEN  = 0;
	localparam int C1_EN   = 5;
	localparam int C1_OV   = 6;
	localparam int C1_WRITE_COLLISION_FLAG = 7;
	localparam int C2_SEN  = 0;
	localparam int C2_LOCK = 5;
	localparam int FL_BCL  = 3;
	localparam int FL_PIF  = 7;

	// reset values and constants
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [4:0] TEN_HI    = 5'h1E;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// controller registers over apb
	localparam logic [7:0] CMD_OFS   = 8'h00;
	localparam logic [7:0] STS_OFS   = 8'h04;
	localparam int         CMD_START = 8;
	localparam int         CMD_STOP  = 9;
	localparam logic [3:0] QTR_CYC   = 4'hA;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_ADDR  = 6'b000010,
		S_AACK  = 6'b000100,
		S_DATA  = 6'b001000,
		S_DACK  = 6'b010000,
		S_HOLD  = 6'b100000
	} slv_st_t;

	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_BRG1 = 4'b0010,
		M_BRG2 = 4'b0100,
		M_HELD = 4'b1000
	} mst_st_t;

	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_START = 4'b0010,
		H_BIT   = 4'b0100,
		H_STOP  = 4'b1000
	} host_st_t;

endpackage

/* hdl/two_wire_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
	logic dev_scl_oe;
	logic dev_sda_oe;
	logic ctl_scl_oe;
	logic ctl_sda_oe;
	logic scl;
	logic sda;

	// open drain with pull-ups
	assign scl = !(dev_scl_oe | ctl_scl_oe);
	assign sda = !(dev_sda_oe | ctl_sda_oe);

	modport dev (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
	modport ctl (input scl, input sda, output ctl_scl_oe, output ctl_sda_oe);
endinterface
`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// pin
	input  wire logic d,
	output logic      q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// change accepted once second and third agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b1;
		end else if (s2_q == s3_q) begin
			q <= s3_q;
		end
	end
endmodule
`default_nettype wire

/* hdl/sync_serial_port.sv */
// The simple cpu_sel/cpu_wr register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port
	import ssp_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// register port
	input  wire logic       cpu_sel,
	input  wire logic       cpu_wr,
	input  wire logic [2:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata,
	// bus
	two_wire_if.dev         bus
);
	slv_st_t    st_q;
	mst_st_t    mst_q;
	logic       scl_s;
	logic       sda_s;
	logic       scl_p_q;
	logic       sda_p_q;
	logic [7:0] sr_q;
	logic [3:0] cnt_q;
	logic [7:0] buf_q;
	logic [7:0] addr_q;
	logic [7:0] ctl2_q;
	logic [6:0] brg_q;
	logic       bf_q, ua_q, rw_q, sb_q, ov_q, en_q, ten_q, write_collision_flag_q, pif_q, bcl_q;
	logic       ack_q, mdrv_q, hold_q, ten_low_q, ten_hit_q;
	logic       scl_oe_q, sda_oe_q;
	logic       scl_rise, scl_fall, start_det, stop_det;
	logic       byte_end, match, rx_take, wr, rd, m_busy, coll, m_begin, m_drive;

	pin_sync u_scl (.core_clk(core_clk), .rst_n(rst_n), .d(bus.scl), .q(scl_s));
	pin_sync u_sda (.core_clk(core_clk), .rst_n(rst_n), .d(bus.sda), .q(sda_s));

	assign bus.dev_scl_oe = scl_oe_q;
	assign bus.dev_sda_oe = sda_oe_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign wr        = cpu_sel & cpu_wr;
	assign rd        = cpu_sel & ~cpu_wr;
	assign byte_end  = scl_fall && (cnt_q == BYTE_BITS) && (st_q == S_ADDR || st_q == S_DATA);

	// address compare
	always_comb begin
		if (ten_q && ten_low_q) begin
			match = (sr_q == addr_q);
		end else if (ten_q) begin
			match = (sr_q[7:3] == TEN_HI) && (sr_q[7:1] == addr_q[7:1]) && (ten_hit_q || !sr_q[0]);
		end else begin
			match = (sr_q[7:1] == addr_q[7:1]);
		end
	end

	assign rx_take = byte_end && (st_q == S_DATA || match);
	assign m_busy  = (mst_q == M_BRG1) || (mst_q == M_BRG2);

	// slave sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
		end else if (!en_q || stop_det) begin
			st_q <= S_IDLE;
		end else if (start_det) begin
			st_q <= S_ADDR;
		end else begin
			unique case (st_q)
				S_IDLE: st_q <= S_IDLE;
				S_ADDR: if (byte_end) begin
					st_q <= match ? S_AACK : S_IDLE;
				end
				S_AACK: if (scl_fall) begin
					st_q <= hold_q ? S_HOLD : S_DATA;
				end
				S_DATA: if (byte_end) begin
					st_q <= S_DACK;
				end
				S_DACK: if (scl_fall) begin
					st_q <= S_DATA;
				end
				S_HOLD: if (wr && cpu_addr == ADDR_OFS) begin
					st_q <= ten_low_q ? S_ADDR : S_DATA;
				end
			endcase
		end
	end

	// bit shifter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_q  <= REG_RST;
			cnt_q <= 4'h0;
		end else if (start_det || (scl_fall && (st_q == S_AACK || st_q == S_DACK))) begin
			cnt_q <= 4'h0;
		end else if (scl_rise && (st_q == S_ADDR || st_q == S_DATA) && cnt_q != BYTE_BITS) begin
			sr_q  <= {sr_q[6:0], sda_s};
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// ten-bit address progress
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q    <= 1'b0;
			ten_low_q <= 1'b0;
			ten_hit_q <= 1'b0;
		end else if (stop_det || !en_q) begin
			ten_low_q <= 1'b0;
			ten_hit_q <= 1'b0;
		end else if (byte_end && st_q == S_ADDR && match) begin
			hold_q    <= ten_q && !ten_hit_q;
			ten_low_q <= ten_q && !ten_hit_q && !ten_low_q;
			ten_hit_q <= ten_hit_q || (ten_q && ten_low_q);
		end
	end

	// ack pulse through the ninth clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else if (rx_take) begin
			ack_q <= !bf_q && !ov_q;
		end else if (scl_fall || stop_det || start_det) begin
			ack_q <= 1'b0;
		end
	end

	// receive buffer and address register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_q  <= REG_RST;
			addr_q <= REG_RST;
		end else begin
			if (rx_take && !bf_q) begin
				buf_q <= sr_q;
			end else if (wr && cpu_addr == BUF_OFS && !m_busy) begin
				buf_q <= cpu_wdata;
			end
			if (wr && cpu_addr == ADDR_OFS) begin
				addr_q <= cpu_wdata;
			end
		end
	end

	// start generator
	assign m_begin = (mst_q == M_IDLE) && ctl2_q[C2_SEN] && en_q && scl_s && sda_s;
	assign coll    = ((mst_q == M_IDLE) && ctl2_q[C2_SEN] && en_q && !scl_s && !sda_s)
		|| ((mst_q == M_BRG1) && (!scl_s || (brg_q == 7'h00 && !sda_s)));
	assign m_drive = (mst_q == M_BRG1) && !coll && brg_q == 7'h00;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_q  <= M_IDLE;
			brg_q  <= 7'h00;
			mdrv_q <= 1'b0;
		end else if (coll || !en_q) begin
			mst_q  <= M_IDLE;
			mdrv_q <= 1'b0;
		end else begin
			unique case (mst_q)
				M_IDLE: if (m_begin) begin
					brg_q <= addr_q[6:0];
					mst_q <= M_BRG1;
				end
				M_BRG1: if (m_drive) begin
					mdrv_q <= 1'b1;
					brg_q  <= addr_q[6:0];
					mst_q  <= M_BRG2;
				end else begin
					brg_q <= brg_q - 7'h01;
				end
				M_BRG2: if (brg_q == 7'h00) begin
					mst_q <= M_HELD;
				end else begin
					brg_q <= brg_q - 7'h01;
				end
				M_HELD: if (wr && cpu_addr == CTL2_OFS) begin
					mdrv_q <= 1'b0;
					mst_q  <= M_IDLE;
				end
			endcase
		end
	end

	// control two
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl2_q <= REG_RST;
		end else if (coll || (mst_q == M_BRG2 && brg_q == 7'h00)) begin
			ctl2_q[C2_SEN] <= 1'b0;
		end else if (wr && cpu_addr == CTL2_OFS) begin
			ctl2_q[7:C2_LOCK] <= cpu_wdata[7:C2_LOCK];
			if (!m_busy) begin
				ctl2_q[C2_LOCK-1:0] <= cpu_wdata[C2_LOCK-1:0];
			end
		end
	end

	// control one bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q  <= 1'b0;
			ten_q <= 1'b0;
		end else if (wr && cpu_addr == CTL1_OFS) begin
			en_q  <= cpu_wdata[C1_EN];
			ten_q <= cpu_wdata[C1_TEN];
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bf_q   <= 1'b0;
			ov_q   <= 1'b0;
			pif_q  <= 1'b0;
			ua_q   <= 1'b0;
			rw_q   <= 1'b0;
			sb_q   <= 1'b0;
			write_collision_flag_q <= 1'b0;
			bcl_q  <= 1'b0;
		end else begin
			if (rx_take && !bf_q) begin
				bf_q <= 1'b1;
			end else if (rd && cpu_addr == BUF_OFS) begin
				bf_q <= 1'b0;
			end
			if (rx_take && bf_q) begin
				ov_q <= 1'b1;
			end else if (wr && cpu_addr == CTL1_OFS) begin
				ov_q <= ov_q & cpu_wdata[C1_OV];
			end
			if (scl_fall && (st_q == S_AACK || st_q == S_DACK)) begin
				pif_q <= 1'b1;
			end else if (wr && cpu_addr == FLAG_OFS) begin
				pif_q <= pif_q & cpu_wdata[FL_PIF];
			end
			if (scl_fall && st_q == S_AACK && hold_q) begin
				ua_q <= 1'b1;
			end else if (wr && cpu_addr == ADDR_OFS) begin
				ua_q <= 1'b0;
			end
			if (rx_take && st_q == S_ADDR) begin
				rw_q <= sr_q[0];
			end
			if (start_det || m_drive) begin
				sb_q <= 1'b1;
			end else if (stop_det) begin
				sb_q <= 1'b0;
			end
			if (wr && cpu_addr == BUF_OFS && m_busy) begin
				write_collision_flag_q <= 1'b1;
			end else if (wr && cpu_addr == CTL1_OFS) begin
				write_collision_flag_q <= write_collision_flag_q & cpu_wdata[C1_WRITE_COLLISION_FLAG];
			end
			if (coll) begin
				bcl_q <= 1'b1;
			end else if (wr && cpu_addr == FLAG_OFS) begin
				bcl_q <= bcl_q & cpu_wdata[FL_BCL];
			end
		end
	end

	// pin drivers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_oe_q <= (st_q == S_HOLD);
			sda_oe_q <= ack_q | mdrv_q;
		end
	end

	// read port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_rdata <= REG_RST;
		end else if (rd) begin
			unique case (cpu_addr)
				BUF_OFS:  cpu_rdata <= buf_q;
				ADDR_OFS: cpu_rdata <= addr_q;
				STAT_OFS: cpu_rdata <= {4'h0, sb_q, rw_q, ua_q, bf_q};
				CTL1_OFS: cpu_rdata <= {write_collision_flag_q, ov_q, en_q, 4'h0, ten_q};
				CTL2_OFS: cpu_rdata <= ctl2_q;
				FLAG_OFS: cpu_rdata <= {pif_q, 3'h0, bcl_q, 3'h0};
				default:  cpu_rdata <= REG_RST;
			endcase
		end
	end
endmodule
`default_nettype wire

/* hdl/bus_master_end.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master_end
	import ssp_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// bus
	two_wire_if.ctl          bus
);
	host_st_t   st_q;
	logic       scl_s, sda_s;
	logic [3:0] div_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, rx_q;
	logic       busy_q, nack_q, stop_q, scl_oe_q, sda_oe_q;
	logic       acc, wdone, tick, adv, go;

	pin_sync u_scl (.core_clk(core_clk), .rst_n(rst_n), .d(bus.scl), .q(scl_s));
	pin_sync u_sda (.core_clk(core_clk), .rst_n(rst_n), .d(bus.sda), .q(sda_s));

	assign bus.ctl_scl_oe = scl_oe_q;
	assign bus.ctl_sda_oe = sda_oe_q;

	assign acc   = psel && penable && !pready;
	assign wdone = psel && penable && pready && pwrite;
	assign go    = wdone && paddr == CMD_OFS && !busy_q;
	assign tick  = (div_q == QTR_CYC - 4'h1);
	// phase two waits while the slave stretches the clock
	assign adv   = tick && (ph_q != 2'h2 || scl_s);

	// apb answer one cycle into access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc;
			pslverr <= acc && paddr != CMD_OFS && paddr != STS_OFS;
			if (acc && !pwrite && paddr == STS_OFS) begin
				prdata <= {16'h0000, rx_q, 6'h00, nack_q, busy_q};
			end else if (acc) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 4'h0;
		end else begin
			div_q <= tick ? 4'h0 : div_q + 4'h1;
		end
	end

	// byte engine, clock made by dividing core_clk
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= H_IDLE;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			sh_q     <= REG_RST;
			rx_q     <= REG_RST;
			busy_q   <= 1'b0;
			nack_q   <= 1'b0;
			stop_q   <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (st_q)
				H_IDLE: if (go) begin
					sh_q   <= pwdata[7:0];
					stop_q <= pwdata[CMD_STOP];
					busy_q <= 1'b1;
					bit_q  <= 4'h0;
					ph_q   <= 2'h0;
					st_q   <= pwdata[CMD_START] ? H_START : H_BIT;
				end
				H_START: if (adv) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_oe_q <= 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						2'h3: begin
							scl_oe_q <= 1'b1;
							st_q     <= H_BIT;
						end
					endcase
				end
				H_BIT: if (adv) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_oe_q <= (bit_q != BYTE_BITS) && !sh_q[7];
						2'h1: scl_oe_q <= 1'b0;
						2'h2: if (bit_q == BYTE_BITS) begin
							nack_q <= sda_s;
						end else begin
							rx_q <= {rx_q[6:0], sda_s};
						end
						2'h3: begin
							scl_oe_q <= 1'b1;
							sh_q     <= {sh_q[6:0], 1'b0};
							bit_q    <= bit_q + 4'h1;
							if (bit_q == BYTE_BITS) begin
								st_q   <= stop_q ? H_STOP : H_IDLE;
								busy_q <= stop_q;
							end
						end
					endcase
				end
				H_STOP: if (adv) begin
					ph_q <= ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						2'h3: begin
							sda_oe_q <= 1'b0;
							busy_q   <= 1'b0;
							st_q     <= H_IDLE;
						end
					endcase
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* sim/ssp_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// wire level
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_idle_after_reset: assert property ($rose(rst_n) |-> !dev_scl_oe && !dev_sda_oe)
		else $error("device drives a line right after reset");
	a_ack_after_fall: assert property ($rose(dev_sda_oe) && !scl |-> !$past(scl, 3))
		else $error("acknowledge starts too soon after clock fall");
	a_ack_low_hold: assert property ($rose(dev_sda_oe) && !scl |-> dev_sda_oe [*8])
		else $error("acknowledge dropped during clock low");
	a_ack_over_high: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
		else $error("acknowledge dropped while clock high");
	a_ack_release: assert property ($fell(scl) && dev_sda_oe |-> ##[1:12] !dev_sda_oe)
		else $error("acknowledge not released after ninth clock");
	a_start_lines_high: assert property ($rose(dev_sda_oe) && scl |-> $past(sda) && !ctl_scl_oe)
		else $error("start drive without both lines high");
	a_start_sda_held: assert property ($rose(dev_sda_oe) && scl |=> dev_sda_oe [*8])
		else $error("start data low not held");
	a_hold_clk_low: assert property ($rose(dev_scl_oe) |-> !$past(scl))
		else $error("clock hold begins while clock high");
	a_hold_min: assert property ($rose(dev_scl_oe) |-> dev_scl_oe [*4])
		else $error("clock hold released too early");

	c_ack: cover property ($rose(dev_sda_oe) && !scl);
	c_hold: cover property ($rose(dev_scl_oe));
	c_start: cover property ($rose(dev_sda_oe) && scl);
endmodule
`default_nettype wire

/* sim/i2c_slave_rx_and_start_gen_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_rx_and_start_gen_tb;
	import ssp_pkg::*;
	logic        core_clk = 0, rst_n = 0, cpu_sel = 0, cpu_wr = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [2:0]  cpu_addr = 0;
	logic [7:0]  cpu_wdata = 0, paddr = 0, cpu_rdata;
	logic [31:0] pwdata = 0, prdata;
	int          n_errors = 0, n_checks = 0;
	two_wire_if tif();
	always #5 core_clk = ~core_clk;

	sync_serial_port sync_serial_port_inst (.core_clk(core_clk), .rst_n(rst_n), .cpu_sel(cpu_sel),
		.cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .bus(tif));
	bus_master_end bus_master_end_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(tif));
	ssp_asserts ssp_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .dev_scl_oe(tif.dev_scl_oe),
		.dev_sda_oe(tif.dev_sda_oe), .ctl_scl_oe(tif.ctl_scl_oe), .ctl_sda_oe(tif.ctl_sda_oe),
		.scl(tif.scl), .sda(tif.sda));

	task close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	function logic [31:0] cmd(input logic [7:0] b, input logic st, input logic sp);
		return 32'(b) | (32'(st) << CMD_START) | (32'(sp) << CMD_STOP);
	endfunction

	task dwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cpu_sel <= 1; cpu_wr <= 1; cpu_addr <= a; cpu_wdata <= d;
		@(posedge core_clk);
		cpu_sel <= 0;
	endtask

	task drd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		cpu_sel <= 1; cpu_wr <= 0; cpu_addr <= a;
		@(posedge core_clk);
		cpu_sel <= 0;
		@(posedge core_clk);
		d = cpu_rdata;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int i;
		@(posedge core_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge core_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		if (i >= 50) begin
			n_errors++;
			close_out();
		end
	endtask

	// send one byte from the host end and wait until it is idle again
	task hb(input logic [7:0] b, input logic st, input logic sp, output logic [31:0] s);
		int i;
		logic e;
		apb(1, CMD_OFS, cmd(b, st, sp), s, e);
		i = 0;
		do begin
			apb(0, STS_OFS, 0, s, e);
			i++;
		end while (s[0] !== 0 && i < 600);
		if (i >= 600) begin
			n_errors++;
			close_out();
		end
		repeat (10) @(posedge core_clk);
	endtask

	initial begin
		logic [31:0] r;
		logic e, bf, ov;
		logic [7:0] v, d, a, bm, lo;
		logic [1:0] h;
		int k;
		void'($urandom(84798));
		repeat (12) @(posedge core_clk);
		rst_n <= 1;
		repeat (6) @(posedge core_clk);
		drd(STAT_OFS, v); chk("stat_rst", v, REG_RST);
		apb(0, 8'h08, 0, r, e); chk("slverr", e, 1);
		// seven-bit address, mismatch then match
		a = 8'($urandom_range(8, 100));
		dwr(CTL1_OFS, 8'h20);
		dwr(ADDR_OFS, {a[6:0], 1'b0});
		hb({a[6:0] ^ 7'h01, 1'b0}, 1, 1, r); chk("nack_miss", r[1], 1);
		hb({a[6:0], 1'b0}, 1, 0, r); chk("ack_addr", r[1], 0);
		drd(STAT_OFS, v); chk("bf_rw", v[2:0], 3'h1);
		drd(FLAG_OFS, v); chk("pif_addr", v[FL_PIF], 1);
		drd(BUF_OFS, v); chk("buf_addr", v, {a[6:0], 1'b0});
		drd(STAT_OFS, v); chk("bf_clr", v[ST_BF], 0);
		dwr(FLAG_OFS, 8'h00);
		// data bytes through full and overflow states
		bf = 0; ov = 0; bm = 0;
		for (k = 0; k < 4; k++) begin
			d = 8'($urandom);
			hb(d, 0, k == 3, r); chk("ack_data", r[1], bf | ov);
			if (bf) ov = 1;
			else bm = d;
			bf = 1;
			drd(FLAG_OFS, v); chk("pif_data", v[FL_PIF], 1);
			drd(CTL1_OFS, v); chk("ov", v[C1_OV], ov);
			dwr(FLAG_OFS, 8'h00);
			if (k > 0) begin
				drd(BUF_OFS, v); chk("buf_data", v, bm);
				bf = 0;
			end
			if (k == 2) begin
				dwr(CTL1_OFS, 8'h20);
				ov = 0;
			end
		end
		// ten-bit addressing with software address swaps
		h = 2'($urandom_range(0, 3));
		lo = 8'($urandom);
		dwr(CTL1_OFS, 8'h21);
		dwr(ADDR_OFS, {TEN_HI, h, 1'b0});
		hb({TEN_HI, h, 1'b0}, 1, 0, r); chk("ack_hi", r[1], 0);
		drd(STAT_OFS, v); chk("ua_hi", v[ST_UA], 1);
		chk("hold_hi", tif.dev_scl_oe, 1);
		dwr(ADDR_OFS, lo);
		drd(STAT_OFS, v); chk("ua_clr", v[ST_UA], 0);
		drd(BUF_OFS, v);
		dwr(FLAG_OFS, 8'h00);
		hb(lo, 0, 0, r); chk("ack_lo", r[1], 0);
		drd(STAT_OFS, v); chk("ua_lo", v[ST_UA], 1);
		dwr(ADDR_OFS, {TEN_HI, h, 1'b0});
		drd(BUF_OFS, v);
		dwr(FLAG_OFS, 8'h00);
		hb({TEN_HI, h, 1'b0}, 1, 0, r); chk("ack_rs", r[1], 0);
		drd(STAT_OFS, v); chk("rs_flags", v[1:0], 2'h1);
		chk("hold_rs", tif.dev_scl_oe, 0);
		drd(BUF_OFS, v);
		hb(8'($urandom), 0, 1, r); chk("ack_rs_data", r[1], 0);
		// start generation with locked writes
		dwr(CTL1_OFS, 8'h20);
		dwr(ADDR_OFS, 8'($urandom_range(20, 40)));
		drd(BUF_OFS, bm);
		dwr(CTL2_OFS, 8'h01);
		dwr(BUF_OFS, ~bm);
		dwr(CTL2_OFS, 8'hE0);
		drd(CTL2_OFS, v); chk("ctl2_lock", v, 8'hE1);
		drd(CTL1_OFS, v); chk("write_collision_flag", v[C1_WRITE_COLLISION_FLAG], 1);
		drd(BUF_OFS, v); chk("buf_keep", v, bm);
		k = 0;
		do begin
			drd(CTL2_OFS, v);
			k++;
		end while (v[C2_SEN] !== 0 && k < 100);
		if (k >= 100) begin
			n_errors++;
			close_out();
		end
		chk("ctl2_done", v, 8'hE0);
		drd(STAT_OFS, v); chk("start_seen", v[ST_S], 1);
		chk("start_lines", {tif.scl, tif.sda, tif.dev_sda_oe}, 3'h5);
		dwr(CTL2_OFS, 8'h00);
		repeat (3) @(posedge core_clk);
		chk("released", {tif.dev_sda_oe, tif.dev_scl_oe}, 2'h0);
		// host takes the bus while the generator counts a long period
		dwr(ADDR_OFS, 8'hFF);
		dwr(CTL2_OFS, 8'h01);
		hb(8'h00, 1, 1, r); chk("nack_coll", r[1], 1);
		drd(FLAG_OFS, v); chk("bcl", v[FL_BCL], 1);
		drd(CTL2_OFS, v); chk("sen_abort", v[C2_SEN], 0);
		chk("coll_free", tif.dev_sda_oe, 0);
		close_out();
	end
endmodule
`default_nettype wire
